// [shared/supply_query_cfg.svh]
// Register offsets, field positions, reset values and codes for the query engine
`ifndef SUPPLY_QUERY_CFG_SVH
`define SUPPLY_QUERY_CFG_SVH

`define ADDR_LIVE_STATUS 8'h00
`define ADDR_STICKY_STATUS 8'h04
`define ADDR_FAULT 8'h08
`define ADDR_FAULT_ENABLE 8'h0c
`define ADDR_MASK_CMD 8'h10
`define ADDR_FAULT_ENABLE_QUERY_CMD 8'h14
`define ADDR_ERROR 8'h18
`define ADDR_AUX 8'h1c
`define ADDR_CONTROL 8'h20
`define ADDR_CLEAR_PON 8'h24
`define ADDR_CAL_CMD 8'h28
`define ADDR_FW_VERSION 8'h2c
`define ADDR_IRQ_STATUS 8'h30
`define ADDR_IRQ_MASK 8'h34

`define AUX_ONE_BIT 0
`define AUX_TWO_BIT 1
`define CTRL_SRQ_BIT 0
`define CTRL_CAL_BIT 1
`define CTRL_OUT_BIT 2
`define CTRL_HOLD_BIT 3
`define IRQ_FAULT_BIT 0
`define IRQ_ERROR_BIT 1
`define IRQ_CAL_DONE_BIT 2

`define BCD_LSB 16
`define FW_SLAVE_LSB 16

`define AUX_RESET 2'h0
`define CTRL_RESET 4'h0
`define FAULT_ENABLE_RESET 8'h00
`define IRQ_MASK_RESET 3'h0

`define ERR_NONE 8'h00
`define ERR_CAL_NOT_ENABLED 8'h01
`define ERR_CAL_BAD_CODE 8'h02

`endif

// [shared/supply_query_pkg.sv]
// Types shared by the supply status query engine
package supply_query_pkg;
   typedef logic [7:0] addr_t;
   typedef logic [31:0] word_t;
   typedef logic [7:0] err_code_t;
   typedef enum logic [2:0] {
      CAL_NONE,
      CAL_CURR_HIGH,
      CAL_CURR_LOW,
      CAL_CURR_COMPUTE,
      CAL_VREAD_HIGH,
      CAL_VREAD_LOW,
      CAL_VREAD_COMPUTE
   } cal_cmd_t;
endpackage

// [core/supply_status_query_engine.sv]
// Status, fault, error and auxiliary query engine behind a register port
`timescale 1ns/100ps
`include "supply_query_cfg.svh"
module supply_status_query_engine #(
   parameter int STATUS_W = 8,
   parameter logic [15:0] MASTER_VERSION = 16'h0101,
   parameter logic [15:0] SLAVE_VERSION = 16'h0102
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire supply_query_pkg::addr_t addr_in,
   input wire supply_query_pkg::word_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output supply_query_pkg::word_t rdata_out,
   input wire logic [STATUS_W-1:0] status_in,
   input wire logic err_valid_in,
   input wire supply_query_pkg::err_code_t err_code_in,
   output logic aux_one_n_out,
   output logic aux_two_n_out,
   output logic srq_enable_out,
   output logic cal_mode_out,
   output logic output_enable_out,
   output logic hold_mode_out,
   output logic clear_pon_out,
   output supply_query_pkg::cal_cmd_t cal_cmd_out,
   output logic cal_strobe_out,
   output logic irq_out
);
   import supply_query_pkg::*;

   localparam int IRQ_W = 3;

   // BCD conversion is sized for three digits
   if (STATUS_W < 1 || STATUS_W > 8) begin : g_width_check
      $error("STATUS_W must lie between 1 and 8");
   end

   logic [STATUS_W-1:0] sticky_reg;
   logic [STATUS_W-1:0] fault_reg;
   logic [STATUS_W-1:0] fault_enable_reg;
   err_code_t err_reg;
   logic [1:0] aux_reg;
   logic [3:0] ctrl_reg;
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   word_t rdata_reg;

   logic wr_mask;
   logic wr_fault_enable_query;
   logic wr_enable;
   logic wr_aux;
   logic wr_ctrl;
   logic wr_clear;
   logic wr_cal;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic rd_live;
   logic rd_sticky;
   logic rd_fault;
   logic rd_enable;
   logic rd_error;
   logic rd_aux;
   logic rd_ctrl;
   logic rd_fw;
   logic rd_irq_status;
   logic rd_irq_mask;
   logic [IRQ_W-1:0] irq_event;
   word_t rdata_next;
   logic [STATUS_W-1:0] wbits;
   logic [STATUS_W-1:0] fault_set;
   logic cal_code_ok;
   logic cal_accept;
   logic cal_reject;
   err_code_t cal_err;

   // Three-digit double dabble
   function automatic logic [11:0] to_bcd(input logic [7:0] bin);
      logic [19:0] sh;
      sh = {12'h000, bin};
      for (int i = 0; i < 8; i++) begin
         if (sh[11:8] > 4'h4) begin
            sh[11:8] = sh[11:8] + 4'h3;
         end
         if (sh[15:12] > 4'h4) begin
            sh[15:12] = sh[15:12] + 4'h3;
         end
         if (sh[19:16] > 4'h4) begin
            sh[19:16] = sh[19:16] + 4'h3;
         end
         sh = {sh[18:0], 1'b0};
      end
      return sh[19:8];
   endfunction

   function automatic word_t status_word(input logic [STATUS_W-1:0] v);
      logic [7:0] b;
      word_t w;
      b = 8'h00;
      b[STATUS_W-1:0] = v;
      w = '0;
      w[7:0] = b;
      w[`BCD_LSB +: 12] = to_bcd(b);
      return w;
   endfunction

   always_comb begin
      wr_mask = 1'b0;
      wr_fault_enable_query = 1'b0;
      wr_enable = 1'b0;
      wr_aux = 1'b0;
      wr_ctrl = 1'b0;
      wr_clear = 1'b0;
      wr_cal = 1'b0;
      wr_irq_status = 1'b0;
      wr_irq_mask = 1'b0;
      if (wr_in) begin
         if (addr_in == `ADDR_MASK_CMD) begin
            wr_mask = 1'b1;
         end else if (addr_in == `ADDR_FAULT_ENABLE_QUERY_CMD) begin
            wr_fault_enable_query = 1'b1;
         end else if (addr_in == `ADDR_FAULT_ENABLE) begin
            wr_enable = 1'b1;
         end else if (addr_in == `ADDR_AUX) begin
            wr_aux = 1'b1;
         end else if (addr_in == `ADDR_CONTROL) begin
            wr_ctrl = 1'b1;
         end else if (addr_in == `ADDR_CLEAR_PON) begin
            wr_clear = 1'b1;
         end else if (addr_in == `ADDR_CAL_CMD) begin
            wr_cal = 1'b1;
         end else if (addr_in == `ADDR_IRQ_STATUS) begin
            wr_irq_status = 1'b1;
         end else if (addr_in == `ADDR_IRQ_MASK) begin
            wr_irq_mask = 1'b1;
         end
      end
   end

   // Read selects; rdata is zero when none is high
   always_comb begin
      rd_live = 1'b0;
      rd_sticky = 1'b0;
      rd_fault = 1'b0;
      rd_enable = 1'b0;
      rd_error = 1'b0;
      rd_aux = 1'b0;
      rd_ctrl = 1'b0;
      rd_fw = 1'b0;
      rd_irq_status = 1'b0;
      rd_irq_mask = 1'b0;
      if (rd_in) begin
         if (addr_in == `ADDR_LIVE_STATUS) begin
            rd_live = 1'b1;
         end else if (addr_in == `ADDR_STICKY_STATUS) begin
            rd_sticky = 1'b1;
         end else if (addr_in == `ADDR_FAULT) begin
            rd_fault = 1'b1;
         end else if (addr_in == `ADDR_FAULT_ENABLE) begin
            rd_enable = 1'b1;
         end else if (addr_in == `ADDR_ERROR) begin
            rd_error = 1'b1;
         end else if (addr_in == `ADDR_AUX) begin
            rd_aux = 1'b1;
         end else if (addr_in == `ADDR_CONTROL) begin
            rd_ctrl = 1'b1;
         end else if (addr_in == `ADDR_FW_VERSION) begin
            rd_fw = 1'b1;
         end else if (addr_in == `ADDR_IRQ_STATUS) begin
            rd_irq_status = 1'b1;
         end else if (addr_in == `ADDR_IRQ_MASK) begin
            rd_irq_mask = 1'b1;
         end
      end
   end

   assign wbits = wdata_in[STATUS_W-1:0];

   assign fault_set = status_in & fault_enable_reg;

   assign cal_code_ok = (wdata_in[2:0] != 3'h0) && (wdata_in[2:0] != 3'h7);
   assign cal_accept = wr_cal && ctrl_reg[`CTRL_CAL_BIT] && cal_code_ok;
   assign cal_reject = wr_cal && !cal_accept;
   assign cal_err = ctrl_reg[`CTRL_CAL_BIT] ? `ERR_CAL_BAD_CODE
                                            : `ERR_CAL_NOT_ENABLED;

   // sticky capture, new set beats read clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sticky_reg <= '0;
      end else if (rd_sticky) begin
         sticky_reg <= status_in;
      end else begin
         sticky_reg <= sticky_reg | status_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fault_enable_reg <= STATUS_W'(`FAULT_ENABLE_RESET);
      end else if (wr_enable) begin
         fault_enable_reg <= wbits;
      end else if (wr_mask) begin
         fault_enable_reg <= fault_enable_reg & ~wbits;
      end else if (wr_fault_enable_query) begin
         fault_enable_reg <= fault_enable_reg | wbits;
      end
   end

   // clear empties faults; live faults reappear at once
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fault_reg <= '0;
      end else if (wr_clear) begin
         fault_reg <= fault_set;
      end else begin
         fault_reg <= fault_reg | fault_set;
      end
   end

   // latest error kept, arrival beats read clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_reg <= `ERR_NONE;
      end else if (err_valid_in) begin
         err_reg <= err_code_in;
      end else if (cal_reject) begin
         err_reg <= cal_err;
      end else if (rd_error) begin
         err_reg <= `ERR_NONE;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         aux_reg <= `AUX_RESET;
      end else if (wr_clear) begin
         aux_reg <= `AUX_RESET;
      end else if (wr_aux) begin
         aux_reg <= wdata_in[1:0];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr_clear) begin
         ctrl_reg <= `CTRL_RESET;
         ctrl_reg[`CTRL_CAL_BIT] <= ctrl_reg[`CTRL_CAL_BIT];
      end else if (wr_ctrl) begin
         ctrl_reg <= wdata_in[3:0];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cal_cmd_out <= CAL_NONE;
         cal_strobe_out <= 1'b0;
      end else begin
         cal_strobe_out <= cal_accept;
         if (cal_accept) begin
            cal_cmd_out <= cal_cmd_t'(wdata_in[2:0]);
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         clear_pon_out <= 1'b0;
      end else begin
         clear_pon_out <= wr_clear;
      end
   end

   // Status flop sees each event in the same cycle it happens
   always_comb begin
      irq_event = '0;
      irq_event[`IRQ_FAULT_BIT] = |(fault_set & ~fault_reg);
      irq_event[`IRQ_ERROR_BIT] = err_valid_in || cal_reject;
      irq_event[`IRQ_CAL_DONE_BIT] = cal_accept;
   end

   // Events beat a write-one clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_status_reg <= '0;
      end else if (wr_irq_status) begin
         irq_status_reg <= (irq_status_reg & ~wdata_in[IRQ_W-1:0])
                           | irq_event;
      end else begin
         irq_status_reg <= irq_status_reg | irq_event;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_mask_reg <= `IRQ_MASK_RESET;
      end else if (wr_irq_mask) begin
         irq_mask_reg <= wdata_in[IRQ_W-1:0];
      end
   end

   // Read data valid only in the cycle after the strobe
   always_comb begin
      rdata_next = '0;
      if (rd_live) begin
         rdata_next = status_word(status_in);
      end else if (rd_sticky) begin
         rdata_next = status_word(sticky_reg | status_in);
      end else if (rd_fault) begin
         rdata_next = status_word(fault_reg);
      end else if (rd_enable) begin
         rdata_next = status_word(fault_enable_reg);
      end else if (rd_error) begin
         rdata_next = {24'h000000, err_reg};
      end else if (rd_aux) begin
         rdata_next = {30'h0, aux_reg};
      end else if (rd_ctrl) begin
         rdata_next = {28'h0000000, ctrl_reg};
      end else if (rd_fw) begin
         rdata_next = {SLAVE_VERSION, MASTER_VERSION};
      end else if (rd_irq_status) begin
         rdata_next = {29'h0, irq_status_reg};
      end else if (rd_irq_mask) begin
         rdata_next = {29'h0, irq_mask_reg};
      end
   end

   // Zero between reads keeps a stale word off the port
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_out = rdata_reg;
   assign aux_one_n_out = ~aux_reg[`AUX_ONE_BIT];
   assign aux_two_n_out = ~aux_reg[`AUX_TWO_BIT];
   assign srq_enable_out = ctrl_reg[`CTRL_SRQ_BIT];
   assign cal_mode_out = ctrl_reg[`CTRL_CAL_BIT];
   assign output_enable_out = ctrl_reg[`CTRL_OUT_BIT];
   assign hold_mode_out = ctrl_reg[`CTRL_HOLD_BIT];
   // Level interrupt, no latency beyond the status flop
   assign irq_out = |(irq_status_reg & irq_mask_reg);
endmodule

// [dv/supply_sensor_model.sv]
// Behavioural model of the sensing side feeding status and errors
`timescale 1ns/100ps
module supply_sensor_model (
   input wire logic clk_in,
   input wire logic [7:0] cond_in,
   input wire logic err_req_in,
   input wire logic [7:0] err_in,
   output logic [7:0] status_out = 8'h00,
   output logic err_valid_out = 1'b0,
   output logic [7:0] err_code_out = 8'h5a
);
   // Conditions reach the card one clock late
   always_ff @(posedge clk_in) begin
      status_out <= cond_in;
      err_valid_out <= err_req_in;
   end
   // Code means nothing outside a pulse, so scramble it there
   always_ff @(posedge clk_in) begin
      err_code_out <= err_req_in ? err_in : ~err_code_out;
   end
endmodule

// [dv/supply_query_properties.sv]
// Port checks for the supply status query engine
`timescale 1ns/100ps
`include "supply_query_cfg.svh"
module supply_query_properties import supply_query_pkg::*; #(
   parameter int STATUS_W = 8,
   parameter logic [15:0] MASTER_VERSION = 16'h0101,
   parameter logic [15:0] SLAVE_VERSION = 16'h0102
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire supply_query_pkg::addr_t addr_in,
   input wire supply_query_pkg::word_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire supply_query_pkg::word_t rdata_out,
   input wire logic [STATUS_W-1:0] status_in,
   input wire logic aux_one_n_out,
   input wire logic aux_two_n_out,
   input wire logic srq_enable_out,
   input wire logic cal_mode_out,
   input wire logic output_enable_out,
   input wire logic hold_mode_out,
   input wire logic clear_pon_out,
   input wire supply_query_pkg::cal_cmd_t cal_cmd_out,
   input wire logic cal_strobe_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == '0)
      else $error("read data not zero outside a read");
   chk_live_read: assert property (rd_in && addr_in == `ADDR_LIVE_STATUS
      |=> rdata_out[STATUS_W-1:0] == $past(status_in))
      else $error("live status read wrong");
   chk_fw_read: assert property (rd_in && addr_in == `ADDR_FW_VERSION
      |=> rdata_out == {SLAVE_VERSION, MASTER_VERSION})
      else $error("firmware versions wrong");
   chk_aux_write: assert property (wr_in && addr_in == `ADDR_AUX
      |=> aux_one_n_out == !$past(wdata_in[0])
      && aux_two_n_out == !$past(wdata_in[1]))
      else $error("aux pins do not follow write");
   chk_ctrl_write: assert property (wr_in && addr_in == `ADDR_CONTROL
      |=> {hold_mode_out, output_enable_out, cal_mode_out, srq_enable_out}
      == $past(wdata_in[3:0]))
      else $error("control outputs do not follow write");
   chk_clear_pulse: assert property (clear_pon_out
      == $past(wr_in && addr_in == `ADDR_CLEAR_PON))
      else $error("clear pulse wrong");
   chk_clear_keeps: assert property (wr_in && addr_in == `ADDR_CLEAR_PON
      |=> $stable(cal_mode_out))
      else $error("clear changed calibration mode");
   chk_cal_accept: assert property (wr_in && addr_in == `ADDR_CAL_CMD
      && cal_mode_out && wdata_in[2:0] inside {[3'd1:3'd6]}
      |=> cal_strobe_out && cal_cmd_out == $past(wdata_in[2:0]))
      else $error("calibration command not accepted");
   chk_cal_refuse: assert property (cal_strobe_out |-> $past(wr_in
      && addr_in == `ADDR_CAL_CMD && cal_mode_out))
      else $error("calibration strobe without accepted write");
endmodule
bind supply_status_query_engine supply_query_properties #(
   .STATUS_W(STATUS_W), .MASTER_VERSION(MASTER_VERSION),
   .SLAVE_VERSION(SLAVE_VERSION)) supply_query_properties_inst (
   .clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
   .status_in, .aux_one_n_out, .aux_two_n_out, .srq_enable_out,
   .cal_mode_out, .output_enable_out, .hold_mode_out, .clear_pon_out,
   .cal_cmd_out, .cal_strobe_out);

// [dv/testbench.sv]
// Self-checking bench for the supply status query engine
`timescale 1ns/100ps
`include "supply_query_cfg.svh"
module testbench;
   import supply_query_pkg::*;
   typedef struct {addr_t wa; word_t wd; addr_t ra; word_t ex;} row_t;
   logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, err_req = 0;
   addr_t addr_in = '0;
   word_t wdata_in = '0, rdata_out, got;
   logic [7:0] cond = 8'hc8, status_in, err_code_in, err_in = '0;
   logic err_valid_in, aux_one_n_out, aux_two_n_out, srq_enable_out;
   logic cal_mode_out, output_enable_out, hold_mode_out, clear_pon_out;
   logic cal_strobe_out, irq_out;
   cal_cmd_t cal_cmd_out;
   int bad_count = 0, n_checks = 0, cycles = 0;
   row_t rows[7];
   always #2.5 clk_in = ~clk_in;
   supply_sensor_model supply_sensor_model_inst (.clk_in, .cond_in(cond),
      .err_req_in(err_req), .err_in, .status_out(status_in),
      .err_valid_out(err_valid_in), .err_code_out(err_code_in));
   supply_status_query_engine supply_status_query_engine_inst (.clk_in,
      .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .status_in,
      .err_valid_in, .err_code_in, .aux_one_n_out, .aux_two_n_out,
      .srq_enable_out, .cal_mode_out, .output_enable_out, .hold_mode_out,
      .clear_pon_out, .cal_cmd_out, .cal_strobe_out, .irq_out);
   // Binary value low, three decimal digits above it
   function automatic word_t sw(input logic [7:0] v);
      sw = {4'h0, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10), 8'h00, v};
   endfunction
   // Outputs other than rdata packed for the reset checks
   function automatic word_t pins();
      pins = 32'({aux_one_n_out, aux_two_n_out, srq_enable_out, cal_mode_out,
         output_enable_out, hold_mode_out, irq_out, clear_pon_out,
         cal_strobe_out, cal_cmd_out});
   endfunction
   task automatic chk(input word_t g, input word_t e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input addr_t a, input word_t d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input addr_t a);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      got = rdata_out;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Run is well under two hundred cycles, so this only catches a hang
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      rows[0] = '{`ADDR_AUX, 32'h3, `ADDR_AUX, 32'h3};
      rows[1] = '{`ADDR_CONTROL, 32'hf, `ADDR_CONTROL, 32'hf};
      rows[2] = '{`ADDR_FAULT_ENABLE, 32'ha5, `ADDR_FAULT_ENABLE, sw(8'ha5)};
      rows[3] = '{8'h3c, 32'hffffffff, 8'h3c, 32'h0};
      rows[4] = '{`ADDR_FW_VERSION, 32'h0, `ADDR_FW_VERSION, 32'h01020101};
      rows[5] = '{`ADDR_LIVE_STATUS, 32'h0, `ADDR_LIVE_STATUS, sw(8'hc8)};
      rows[6] = '{`ADDR_FAULT, 32'hff, `ADDR_FAULT, sw(8'h80)};
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      chk(pins(), 32'hc00);
      chk(rdata_out, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra);
         chk(got, rows[i].ex);
      end
      $display("table test done");
      @(posedge clk_in);
      cond <= 8'h00;
      rd(`ADDR_STICKY_STATUS);
      chk(got, sw(8'hc8));
      rd(`ADDR_STICKY_STATUS);
      chk(got, 32'h0);
      @(posedge clk_in);
      cond <= 8'h95;
      @(posedge clk_in);
      cond <= 8'h00;
      repeat (3) @(posedge clk_in);
      rd(`ADDR_STICKY_STATUS);
      chk(got, sw(8'h95));
      rd(`ADDR_STICKY_STATUS);
      chk(got, 32'h0);
      $display("sticky test done");
      wr(`ADDR_MASK_CMD, 32'h80);
      rd(`ADDR_FAULT_ENABLE);
      chk(got, sw(8'h25));
      @(posedge clk_in);
      cond <= 8'hff;
      repeat (3) @(posedge clk_in);
      wr(`ADDR_CLEAR_PON, 32'h0);
      @(negedge clk_in);
      chk(32'({cal_mode_out, srq_enable_out, aux_one_n_out}), 32'h5);
      rd(`ADDR_FAULT);
      chk(got, sw(8'h25));
      wr(`ADDR_FAULT_ENABLE_QUERY_CMD, 32'h40);
      rd(`ADDR_FAULT);
      chk(got, sw(8'h65));
      $display("fault test done");
      wr(`ADDR_IRQ_MASK, 32'h2);
      @(posedge clk_in);
      err_req <= 1'b1;
      err_in <= 8'h33;
      @(posedge clk_in);
      err_in <= 8'h44;
      @(posedge clk_in);
      err_req <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk(32'(irq_out), 32'h1);
      rd(`ADDR_ERROR);
      chk(got, 32'h44);
      rd(`ADDR_ERROR);
      chk(got, 32'h0);
      wr(`ADDR_IRQ_STATUS, 32'h7);
      @(negedge clk_in);
      chk(32'(irq_out), 32'h0);
      $display("error and irq test done");
      for (int c = 1; c < 8; c++) begin
         wr(`ADDR_CAL_CMD, 32'(c));
         @(negedge clk_in);
         chk(32'({cal_strobe_out, cal_cmd_out}), 32'(c < 7 ? 8 + c : 6));
      end
      rd(`ADDR_IRQ_STATUS);
      chk(got, 32'h6);
      rd(`ADDR_ERROR);
      chk(got, 32'h2);
      wr(`ADDR_CONTROL, 32'h0);
      wr(`ADDR_CAL_CMD, 32'h1);
      rd(`ADDR_ERROR);
      chk(got, 32'h1);
      $display("calibration test done");
      wr(`ADDR_AUX, 32'h3);
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      chk(pins(), 32'hc00);
      rd(`ADDR_AUX);
      chk(got, 32'h0);
      $display("mid-run reset test done");
      end_sim();
   end
endmodule
